// file: core/msc_pkg.sv
// Contract
// - in auto, forward and reverse command bits together mean reset, not drive
// - then both high at least 18.5 ms; only then the reset executes
// - trip clears on key move auto/manual to off, held about half a second
// - overload trip refuses reset until thermal memory or thermistor says fit
// - 24 V failure error to master clears by itself when 24 V returns
// - peripheral fault when bus power present but 24 V never came up
// - motor current with contactor off is an internal fault, raises peripheral fault
// - peripheral fault flashes the bus-error indicator; master lists such slaves
// - internal fault also flashes motor and both direction indicators
// - parameter pattern 111 returns the diagnostic status
// - internal fault clears on 24 V removal, key reset or bus reset
// - manual direction held over 24 V loss blocks restart, flashes until key reset
// - lower-limit manual-only option: 400 V loss in manual gives group fault
// - key switch: auto drives from bus, off removes drive and resets, manual local
// - phase-reversal bit selects which contactor serves the forward command
// - quick stop switches drive off in local logic, no bus latency
// - quick-stop maps: A both; A fwd B rev; A and B fwd
// - each external input configurable as quick stop or interlock limit
// - interlock: input A bounds forward, input B bounds reverse
// - interlock stops manual drive even while selector stays actuated
// - replacement with key off and auto-addressing blanks error indicators quickly
// - quick-stop rising edge latches stop until master clears the command bit
// - any other parameter value is echoed back unchanged
package msc_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned MSC_CLK_NS = 50;
  localparam int unsigned MSC_CMD_MIN_US = 18500;
  localparam int unsigned MSC_KEY_HOLD_MS = 500;
  localparam int unsigned MSC_DEB_MS = 5;
  localparam int unsigned MSC_BLINK_MS = 250;
  localparam int unsigned MSC_CMD_CYC = (MSC_CMD_MIN_US * 1000 + MSC_CLK_NS - 1) / MSC_CLK_NS;
  localparam int unsigned MSC_KEY_CYC = (MSC_KEY_HOLD_MS * 1000000 + MSC_CLK_NS - 1) / MSC_CLK_NS;
  localparam int unsigned MSC_DEB_CYC = (MSC_DEB_MS * 1000000 + MSC_CLK_NS - 1) / MSC_CLK_NS;
  localparam int unsigned MSC_BLINK_CYC = MSC_BLINK_MS * 1000000 / MSC_CLK_NS;
  localparam int MSC_CNT_W = 24;
  // ****************************************
  // register map and fields
  // ****************************************
  localparam logic [11:0] MSC_CFG_ADDR = 12'h000;
  localparam logic [11:0] MSC_STAT_ADDR = 12'h004;
  localparam logic [5:0] MSC_CFG_RST = 6'h00;
  localparam int MSC_CFG_PHREV = 0;
  localparam int MSC_CFG_QSMAP = 1;
  localparam int MSC_CFG_ILA = 3;
  localparam int MSC_CFG_ILB = 4;
  localparam int MSC_CFG_LCL = 5;
  localparam logic [1:0] MSC_QS_BOTH = 2'h0;
  localparam logic [1:0] MSC_QS_SPLIT = 2'h1;
  localparam logic [1:0] MSC_QS_FWD2 = 2'h2;
  // ****************************************
  // parameter channel and diagnostic codes
  // ****************************************
  localparam logic [2:0] MSC_PRM_DIAG = 3'h7;
  localparam logic [2:0] MSC_DG_CONT = 3'h1;
  localparam logic [2:0] MSC_DG_OVL = 3'h2;
  localparam logic [2:0] MSC_DG_THM = 3'h3;
  localparam logic [2:0] MSC_DG_MAN = 3'h4;
  localparam logic [2:0] MSC_DG_NONE = 3'h7;
  typedef enum logic [3:0] {
    MSC_WLOW = 4'h1,
    MSC_ARM = 4'h2,
    MSC_WHIGH = 4'h4,
    MSC_DONE = 4'h8
  } msc_brst_e;
endpackage

// file: core/msc_core.sv
`timescale 1ns/1ps
module msc_core
  import msc_pkg::*;
#(
  parameter int unsigned CMD_CYC = MSC_CMD_CYC,
  parameter int unsigned KEY_CYC = MSC_KEY_CYC,
  parameter int unsigned DEB_CYC = MSC_DEB_CYC,
  parameter int unsigned BLINK_CYC = MSC_BLINK_CYC
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // local switches and limit inputs (pins)
  input wire logic key_auto,
  input wire logic key_manual,
  input wire logic forward_select,
  input wire logic reverse_select,
  input wire logic limit_input_a,
  input wire logic limit_input_b,
  // supply and motor sensing (pins)
  input wire logic bus_power_ok,
  input wire logic supply_24v_ok,
  input wire logic supply_400v_ok,
  input wire logic motor_current,
  input wire logic overload_hot,
  input wire logic thermistor_hot,
  input wire logic auto_addr_active,
  // bus slave side, same clock
  input wire logic forward_command_bit,
  input wire logic reverse_command_bit,
  input wire logic param_wr,
  input wire logic [2:0] param_data,
  output logic [2:0] param_resp,
  output logic group_fault,
  output logic peripheral_fault_flag,
  // contactors and indicators
  output logic contactor_main,
  output logic contactor_rev,
  output logic led_motor,
  output logic led_fwd,
  output logic led_rev,
  output logic led_bus_err
);
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic at_lim(input logic [MSC_CNT_W-1:0] c, input int unsigned lim);
    at_lim = c >= MSC_CNT_W'(lim - 1);
  endfunction
  function automatic logic [MSC_CNT_W-1:0] inc(input logic [MSC_CNT_W-1:0] c);
    inc = c + MSC_CNT_W'(1);
  endfunction

  // ****************************************
  // input synchronisers and debounce
  // ****************************************
  logic [12:0] s1_q, s2_q;
  logic [5:0] deb_q, deb_d, smp_q, lim_prev_q;
  logic [MSC_CNT_W-1:0] deb_cnt_q;
  wire logic deb_tick = at_lim(deb_cnt_q, DEB_CYC);
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      s1_q <= '0;
      s2_q <= '0;
    end
    else
    begin
      s1_q <= {auto_addr_active, thermistor_hot, overload_hot, motor_current,
               supply_400v_ok, supply_24v_ok, bus_power_ok, limit_input_b,
               limit_input_a, reverse_select, forward_select, key_manual, key_auto};
      s2_q <= s1_q;
    end
  // a bit changes only after two agreeing samples one debounce period apart
  assign deb_d = (s2_q[5:0] & smp_q) | (deb_q & (s2_q[5:0] | smp_q));
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      deb_cnt_q <= '0;
      smp_q <= '0;
      deb_q <= '0;
      lim_prev_q <= '0;
    end
    else
    begin
      deb_cnt_q <= deb_tick ? '0 : inc(deb_cnt_q);
      if (deb_tick)
      begin
        smp_q <= s2_q[5:0];
        deb_q <= deb_d;
      end
      lim_prev_q <= deb_q;
    end
  wire logic k_auto = deb_q[0] & ~deb_q[1];
  wire logic k_man = deb_q[1] & ~deb_q[0];
  wire logic k_off = ~k_auto & ~k_man;
  wire logic sel_f = deb_q[2] & ~deb_q[3];
  wire logic sel_r = deb_q[3] & ~deb_q[2];
  wire logic lim_a = deb_q[4];
  wire logic lim_b = deb_q[5];
  wire logic rise_a = deb_q[4] & ~lim_prev_q[4];
  wire logic rise_b = deb_q[5] & ~lim_prev_q[5];
  wire logic bus_pwr = s2_q[6];
  wire logic sup24 = s2_q[7];
  wire logic sup400 = s2_q[8];
  wire logic mot_cur = s2_q[9];
  wire logic ovl_hot = s2_q[10];
  wire logic thm_hot = s2_q[11];
  wire logic auto_addr = s2_q[12];

  // ****************************************
  // configuration register
  // ****************************************
  logic [5:0] cfg_q;
  wire logic phase_rev = cfg_q[MSC_CFG_PHREV];
  wire logic [1:0] qs_map = cfg_q[MSC_CFG_QSMAP +: 2];
  wire logic il_a = cfg_q[MSC_CFG_ILA];
  wire logic il_b = cfg_q[MSC_CFG_ILB];
  wire logic lcl_man = cfg_q[MSC_CFG_LCL];

  // ****************************************
  // key-switch reset: off held after auto or manual
  // ****************************************
  logic key_armed_q, key_rst_q;
  logic [MSC_CNT_W-1:0] key_cnt_q;
  wire logic key_rst_now = k_off & key_armed_q & at_lim(key_cnt_q, KEY_CYC);
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      key_armed_q <= 1'b0;
      key_cnt_q <= '0;
      key_rst_q <= 1'b0;
    end
    else
    begin
      key_armed_q <= ~k_off | (key_armed_q & ~key_rst_now);
      key_cnt_q <= k_off ? inc(key_cnt_q) : '0;
      key_rst_q <= key_rst_now;
    end

  // ****************************************
  // bus reset: both bits low, then both high
  // ****************************************
  msc_brst_e br_q, br_d;
  logic [MSC_CNT_W-1:0] br_cnt_q;
  logic bus_rst_q;
  wire logic both_lo = ~forward_command_bit & ~reverse_command_bit;
  wire logic both_hi = forward_command_bit & reverse_command_bit;
  wire logic br_tmo = at_lim(br_cnt_q, CMD_CYC);
  wire logic bus_rst_now = (br_q == MSC_WHIGH) & both_hi & br_tmo;
  always_comb
  begin
    br_d = br_q;
    unique case (br_q)
      MSC_WLOW: if (both_lo && br_tmo) br_d = MSC_ARM;
      MSC_ARM: if (both_hi) br_d = MSC_WHIGH;
        else if (!both_lo) br_d = MSC_WLOW;
      MSC_WHIGH: if (!both_hi) br_d = MSC_WLOW;
        else if (br_tmo) br_d = MSC_DONE;
      MSC_DONE: if (!both_hi) br_d = MSC_WLOW;
      default: br_d = MSC_WLOW;
    endcase
    if (!k_auto) br_d = MSC_WLOW;
  end
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      br_q <= MSC_WLOW;
      br_cnt_q <= '0;
      bus_rst_q <= 1'b0;
    end
    else
    begin
      br_q <= br_d;
      br_cnt_q <= (br_d != br_q || (br_q == MSC_WLOW && !both_lo)) ? '0 : inc(br_cnt_q);
      bus_rst_q <= bus_rst_now & k_auto;
    end
  wire logic any_rst = key_rst_q | bus_rst_q;

  // ****************************************
  // faults
  // ****************************************
  logic trip_ovl_q, trip_thm_q, int_q, seen24_q, lcl_q, man_lock_q;
  logic drv_f_q, drv_r_q;
  logic contactor_main_q, contactor_rev_q;
  wire logic cont_on = contactor_main_q | contactor_rev_q;
  wire logic pf24 = bus_pwr & ~sup24 & ~seen24_q;
  wire logic pf_d = pf24 | int_q;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      trip_ovl_q <= 1'b0;
      trip_thm_q <= 1'b0;
      int_q <= 1'b0;
      seen24_q <= 1'b0;
      lcl_q <= 1'b0;
      man_lock_q <= 1'b0;
    end
    else
    begin
      // trips clear only when the motor is fit again; set wins over clear
      trip_ovl_q <= ovl_hot | (trip_ovl_q & ~any_rst);
      trip_thm_q <= thm_hot | (trip_thm_q & ~any_rst);
      int_q <= (mot_cur & ~cont_on) | (int_q & ~any_rst & sup24);
      seen24_q <= bus_pwr & (sup24 | seen24_q);
      lcl_q <= (lcl_man & k_man & ~sup400) | (lcl_q & ~any_rst);
      man_lock_q <= (k_man & (sel_f | sel_r) & ~sup24) | (man_lock_q & ~key_rst_q);
    end
  wire logic trip = trip_ovl_q | trip_thm_q;
  wire logic hot = ovl_hot | thm_hot;
  // 24 V loss is reported but needs no acknowledge
  wire logic gf_d = trip | int_q | lcl_q | ~sup24;
  wire logic block = trip | int_q | lcl_q | k_off | ~sup24;

  // ****************************************
  // quick stop and interlocked manual
  // ****************************************
  logic qs_f_q, qs_r_q, il_f_q, il_r_q;
  wire logic qa = ~il_a & rise_a;
  wire logic qb = ~il_b & rise_b;
  wire logic qs_f_set = qa | (qb & (qs_map == MSC_QS_FWD2));
  wire logic qs_r_set = (qa & (qs_map == MSC_QS_BOTH)) | (qb & (qs_map == MSC_QS_SPLIT));
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      qs_f_q <= 1'b0;
      qs_r_q <= 1'b0;
      il_f_q <= 1'b0;
      il_r_q <= 1'b0;
    end
    else
    begin
      // released only when the master drops its command bit
      qs_f_q <= qs_f_set | (qs_f_q & forward_command_bit);
      qs_r_q <= qs_r_set | (qs_r_q & reverse_command_bit);
      il_f_q <= (il_a & lim_a) | (il_f_q & ~(k_auto | (sel_r & ~lim_a)));
      il_r_q <= (il_b & lim_b) | (il_r_q & ~(k_auto | (sel_f & ~lim_b)));
    end

  // ****************************************
  // drive selection
  // ****************************************
  wire logic want_f = k_auto ? (forward_command_bit & ~reverse_command_bit) : (k_man & sel_f);
  wire logic want_r = k_auto ? (reverse_command_bit & ~forward_command_bit) : (k_man & sel_r);
  // quick-stop terms bypass the bus so stop latency is one cycle
  wire logic stop_f = k_auto ? (qs_f_q | qs_f_set) : (il_f_q | man_lock_q);
  wire logic stop_r = k_auto ? (qs_r_q | qs_r_set) : (il_r_q | man_lock_q);
  wire logic go_f = want_f & ~stop_f & ~block;
  wire logic go_r = want_r & ~stop_r & ~block;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      drv_f_q <= 1'b0;
      drv_r_q <= 1'b0;
      contactor_main_q <= 1'b0;
      contactor_rev_q <= 1'b0;
    end
    else
    begin
      drv_f_q <= go_f;
      drv_r_q <= go_r;
      contactor_main_q <= phase_rev ? go_r : go_f;
      contactor_rev_q <= phase_rev ? go_f : go_r;
    end

  // ****************************************
  // indicators
  // ****************************************
  logic blink_q, led_motor_q, led_fwd_q, led_rev_q, led_bus_err_q, gf_q, pf_q;
  logic [MSC_CNT_W-1:0] blink_cnt_q;
  wire logic blank = k_off & auto_addr;
  wire logic fl_f = want_f & ~go_f & (stop_f | man_lock_q);
  wire logic fl_r = want_r & ~go_r & (stop_r | man_lock_q);
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      blink_cnt_q <= '0;
      blink_q <= 1'b0;
      led_motor_q <= 1'b0;
      led_fwd_q <= 1'b0;
      led_rev_q <= 1'b0;
      led_bus_err_q <= 1'b0;
      gf_q <= 1'b0;
      pf_q <= 1'b0;
    end
    else
    begin
      blink_cnt_q <= at_lim(blink_cnt_q, BLINK_CYC) ? '0 : inc(blink_cnt_q);
      blink_q <= blink_q ^ at_lim(blink_cnt_q, BLINK_CYC);
      // steady while still hot, flashing once a reset would be accepted
      led_motor_q <= ~blank & ((trip & (hot | blink_q)) | (int_q & blink_q) | lcl_q);
      led_fwd_q <= ~blank & (int_q ? blink_q : (go_f | (fl_f & blink_q)));
      led_rev_q <= ~blank & (int_q ? blink_q : (go_r | (fl_r & blink_q)));
      led_bus_err_q <= ~blank & pf_d & blink_q;
      gf_q <= gf_d;
      pf_q <= pf_d;
    end

  // ****************************************
  // parameter channel
  // ****************************************
  logic [2:0] param_resp_q;
  wire logic [2:0] diag = int_q ? MSC_DG_CONT : trip_ovl_q ? MSC_DG_OVL :
    trip_thm_q ? MSC_DG_THM : k_man ? MSC_DG_MAN : MSC_DG_NONE;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      param_resp_q <= MSC_DG_NONE;
    else if (param_wr)
      param_resp_q <= (param_data == MSC_PRM_DIAG) ? diag : param_data;

  // ****************************************
  // apb slave, one wait state
  // ****************************************
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q;
  wire logic acc = psel & penable & ~pready_q;
  wire logic hit_cfg = paddr == MSC_CFG_ADDR;
  wire logic hit_stat = paddr == MSC_STAT_ADDR;
  wire logic [31:0] stat_w = {16'h0000, br_q, qs_r_q, qs_f_q, il_r_q, il_f_q, man_lock_q,
    lcl_q, int_q, trip_thm_q, trip_ovl_q, pf_q, gf_q, k_auto};
  wire logic [31:0] rd_w = hit_cfg ? {26'h0000000, cfg_q} : hit_stat ? stat_w : 32'h00000000;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cfg_q <= MSC_CFG_RST;
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q <= acc;
      pslverr_q <= acc & ~hit_cfg & ~(hit_stat & ~pwrite);
      prdata_q <= (acc & ~pwrite) ? rd_w : '0;
      if (acc & pwrite & hit_cfg)
        cfg_q <= pwdata[5:0];
    end

  // ****************************************
  // outputs
  // ****************************************
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign param_resp = param_resp_q;
  assign group_fault = gf_q;
  assign peripheral_fault_flag = pf_q;
  assign contactor_main = contactor_main_q;
  assign contactor_rev = contactor_rev_q;
  assign led_motor = led_motor_q;
  assign led_fwd = led_fwd_q;
  assign led_rev = led_rev_q;
  assign led_bus_err = led_bus_err_q;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_both_no_drive: assert property (k_auto && both_hi |=> !drv_f_q && !drv_r_q)
    else $error("both command bits produced a drive");
  a_bus_rst_hold: assert property (bus_rst_now |-> both_hi && br_cnt_q >= MSC_CNT_W'(CMD_CYC - 1))
    else $error("bus reset before high time");
  a_arm_low: assert property ($rose(br_q == MSC_ARM) |-> $past(both_lo) && $past(br_tmo))
    else $error("armed without low period");
  a_trip_hot: assert property (trip_ovl_q && ovl_hot |=> trip_ovl_q)
    else $error("overload trip cleared while hot");
  a_int_set: assert property (mot_cur && !cont_on |=> int_q ##1 pf_q)
    else $error("internal fault not raised");
  a_pf_commission: assert property (pf24 |=> pf_q)
    else $error("peripheral fault missing");
  a_off_drive: assert property (k_off |=> !contactor_main_q && !contactor_rev_q)
    else $error("drive while key off");
  a_qs_stop: assert property (k_auto && qs_f_set |=> !drv_f_q [*2])
    else $error("quick stop did not stop forward");
  a_phase_map: assert property (go_f && !phase_rev |=> contactor_main_q && !contactor_rev_q)
    else $error("forward contactor mapping wrong");
  a_echo: assert property (param_wr && param_data != MSC_PRM_DIAG
    |=> param_resp_q == $past(param_data))
    else $error("parameter echo wrong");
  c_bus_reset: cover property (bus_rst_q);
  c_key_reset: cover property (key_rst_q && trip_ovl_q);
  c_quick_stop: cover property (qs_f_q && forward_command_bit);
  c_interlock: cover property (il_f_q && k_man && sel_f);
endmodule

// file: tb/msc_plc_model.sv
`timescale 1ns/1ps
// ****************************************
// bus master stand-in: command bits and parameter channel
// ****************************************
module msc_plc_model
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // slave status
  input wire logic peripheral_fault_flag,
  // commands and parameters
  output logic forward_command_bit,
  output logic reverse_command_bit,
  output logic param_wr,
  output logic [2:0] param_data
);
  logic peripheral_fault_slave_list;
  initial
  begin
    forward_command_bit = 1'b0;
    reverse_command_bit = 1'b0;
    param_wr = 1'b0;
    param_data = 3'h0;
  end
  // one slave only, so the list is a single sticky bit
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      peripheral_fault_slave_list <= 1'b0;
    else if (peripheral_fault_flag)
      peripheral_fault_slave_list <= 1'b1;
  task automatic drive(input logic f, input logic r);
    @(posedge pclk);
    forward_command_bit <= f;
    reverse_command_bit <= r;
  endtask
  // both phases run three cycles past the count; a short count tests refusal
  task automatic bus_reset(input int cyc);
    drive(1'b0, 1'b0);
    repeat (cyc + 2) @(posedge pclk);
    drive(1'b1, 1'b1);
    repeat (cyc + 2) @(posedge pclk);
    drive(1'b0, 1'b0);
  endtask
  task automatic write_param(input logic [2:0] v);
    @(posedge pclk);
    param_wr <= 1'b1;
    param_data <= v;
    @(posedge pclk);
    param_wr <= 1'b0;
    param_data <= ~v;
  endtask
endmodule

// file: tb/tb_motor_starter_control.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    total_checks++; \
    if ((g) !== (e)) \
    begin \
      num_errors++; \
      $display("[ERR] %s expected %0h seen %0h", nm, e, g); \
    end \
  end
module tb_motor_starter_control;
  import msc_pkg::*;
  // ****************************************
  // harness
  // ****************************************
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, bad, seen_m, seen_b;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic key_auto, key_manual, forward_select, reverse_select, limit_input_a, limit_input_b;
  logic bus_power_ok, supply_24v_ok, supply_400v_ok, motor_current, overload_hot;
  logic thermistor_hot, auto_addr_active, fwd_b, rev_b, param_wr, group_fault, pff;
  logic contactor_main, contactor_rev, led_motor, led_fwd, led_rev, led_bus_err;
  logic [2:0] param_data, param_resp, e3;
  logic [2:0] exp_q[$];
  int num_errors, total_checks;
  msc_core #(.CMD_CYC(8), .KEY_CYC(10), .DEB_CYC(2), .BLINK_CYC(4)) DUT (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .key_auto(key_auto), .key_manual(key_manual), .forward_select(forward_select),
    .reverse_select(reverse_select), .limit_input_a(limit_input_a),
    .limit_input_b(limit_input_b), .bus_power_ok(bus_power_ok),
    .supply_24v_ok(supply_24v_ok), .supply_400v_ok(supply_400v_ok),
    .motor_current(motor_current), .overload_hot(overload_hot),
    .thermistor_hot(thermistor_hot), .auto_addr_active(auto_addr_active),
    .forward_command_bit(fwd_b), .reverse_command_bit(rev_b), .param_wr(param_wr),
    .param_data(param_data), .param_resp(param_resp), .group_fault(group_fault),
    .peripheral_fault_flag(pff), .contactor_main(contactor_main),
    .contactor_rev(contactor_rev), .led_motor(led_motor), .led_fwd(led_fwd),
    .led_rev(led_rev), .led_bus_err(led_bus_err));
  msc_plc_model PLC (.pclk(pclk), .presetn(presetn), .peripheral_fault_flag(pff),
    .forward_command_bit(fwd_b), .reverse_command_bit(rev_b), .param_wr(param_wr),
    .param_data(param_data));
  always #25 pclk = ~pclk;
  // ready is read before the edge's own updates land, so it is the sampled value
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count assumed: only the watchdog ends a hung wait
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic prm(input logic [2:0] v, input logic [2:0] e);
    PLC.write_param(v);
    exp_q.push_back(e);
    @(posedge pclk);
    e3 = exp_q.pop_front();
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (6000) @(posedge pclk);
    num_errors++;
    print_verdict();
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {key_auto, key_manual, forward_select, reverse_select, limit_input_a} = '0;
    {limit_input_b, motor_current, overload_hot, thermistor_hot, auto_addr_active} = '0;
    {bus_power_ok, supply_24v_ok, supply_400v_ok} = 3'h5;
    num_errors = 0;
    total_checks = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    void'($urandom(32'h032C70D8));
    @(posedge pclk);
    `CHK("param_resp", 3'h7, param_resp);
    repeat (6) @(posedge pclk);
    `CHK("pff", 1'b1, pff);
    supply_24v_ok <= 1'b1;
    repeat (8) @(posedge pclk);
    `CHK("group_fault", 1'b0, group_fault);
    supply_24v_ok <= 1'b0;
    repeat (8) @(posedge pclk);
    `CHK("pff", 1'b0, pff);
    supply_24v_ok <= 1'b1;
    apb(1'b0, MSC_CFG_ADDR, 32'h0);
    `CHK("cfg", 32'h0, rd);
    apb(1'b1, MSC_STAT_ADDR, 32'h1);
    `CHK("slverr", 1'b1, err);
    apb(1'b0, 12'h008, 32'h0);
    `CHK("slverr", 1'b1, err);
    apb(1'b1, MSC_CFG_ADDR, 32'h1);
    key_auto <= 1'b1;
    repeat (20) @(posedge pclk);
    PLC.drive(1'b1, 1'b0);
    repeat (2) @(posedge pclk);
    `CHK("rev", 2'b01, {contactor_main, contactor_rev});
    apb(1'b1, MSC_CFG_ADDR, 32'h0);
    repeat (2) @(posedge pclk);
    `CHK("main", 2'b10, {contactor_main, contactor_rev});
    limit_input_a <= 1'b1;
    repeat (10) @(posedge pclk);
    `CHK("main", 1'b0, contactor_main);
    limit_input_a <= 1'b0;
    repeat (10) @(posedge pclk);
    `CHK("main", 1'b0, contactor_main);
    PLC.drive(1'b0, 1'b0);
    PLC.drive(1'b1, 1'b0);
    repeat (2) @(posedge pclk);
    `CHK("main", 1'b1, contactor_main);
    PLC.drive(1'b0, 1'b0);
    motor_current <= 1'b1;
    repeat (6) @(posedge pclk);
    `CHK("pff", 1'b1, pff);
    {seen_m, seen_b} = 2'b00;
    repeat (12)
    begin
      @(posedge pclk);
      seen_m |= led_motor & led_fwd & led_rev;
      seen_b |= led_bus_err;
    end
    `CHK("led_motor", 1'b1, seen_m);
    `CHK("led_bus_err", 1'b1, seen_b);
    `CHK("slave_list", 1'b1, PLC.peripheral_fault_slave_list);
    motor_current <= 1'b0;
    prm(3'h7, MSC_DG_CONT);
    `CHK("diag", e3, param_resp);
    PLC.bus_reset(4);
    repeat (4) @(posedge pclk);
    `CHK("pff", 1'b1, pff);
    bad = 1'b0;
    fork
      PLC.bus_reset(8);
      repeat (24)
      begin
        @(posedge pclk);
        bad |= contactor_main | contactor_rev;
      end
    join
    `CHK("drive", 1'b0, bad);
    repeat (4) @(posedge pclk);
    `CHK("pff", 1'b0, pff);
    prm(3'h7, MSC_DG_NONE);
    `CHK("diag", e3, param_resp);
    for (int i = 0; i < 6; i++)
    begin
      rd = $urandom % 7;
      prm(rd[2:0], rd[2:0]);
      `CHK("echo", e3, param_resp);
    end
    apb(1'b1, MSC_CFG_ADDR, 32'h8);
    key_auto <= 1'b0;
    key_manual <= 1'b1;
    forward_select <= 1'b1;
    repeat (20) @(posedge pclk);
    `CHK("main", 1'b1, contactor_main);
    limit_input_a <= 1'b1;
    repeat (10) @(posedge pclk);
    `CHK("main", 1'b0, contactor_main);
    overload_hot <= 1'b1;
    repeat (6) @(posedge pclk);
    `CHK("group_fault", 1'b1, group_fault);
    prm(3'h7, MSC_DG_OVL);
    `CHK("diag", e3, param_resp);
    // key reset while still hot must not clear the trip
    key_manual <= 1'b0;
    repeat (24) @(posedge pclk);
    `CHK("group_fault", 1'b1, group_fault);
    `CHK("led_motor", 1'b1, led_motor);
    auto_addr_active <= 1'b1;
    repeat (6) @(posedge pclk);
    `CHK("led_motor", 1'b0, led_motor);
    auto_addr_active <= 1'b0;
    overload_hot <= 1'b0;
    key_manual <= 1'b1;
    repeat (24) @(posedge pclk);
    key_manual <= 1'b0;
    repeat (24) @(posedge pclk);
    `CHK("group_fault", 1'b0, group_fault);
    print_verdict();
  end
endmodule
